// >>> srw_pkg.sv
/*
 * Shared constants for the supervisor reset and watchdog block: timebase rate,
 * timeout and pulse lengths in timebase ticks, and synchroniser depth.
 * Assumes a single 50 MHz system clock feeds every consumer of this package.
 */
package srw_pkg;
   localparam int unsigned MCLK_HZ = 50000000;
   // Nominal internal oscillator rate; internal-mode timeouts are counted in its ticks.
   localparam int unsigned TB_HZ = 6550;
   localparam int unsigned TB_DIV_CYCLES = MCLK_HZ / TB_HZ;
   localparam int unsigned TB_DIV_W = 13;
   // Times in their own units.
   localparam int unsigned RST_SHORT_MS = 50;
   localparam int unsigned RST_LONG_MS = 200;
   localparam int unsigned WD_SLOW_MS = 1600;
   localparam int unsigned WD_FAST_MS = 100;
   // Tick counts; table figures for the external clock path.
   localparam int unsigned RST_SHORT_TICKS = RST_SHORT_MS * TB_HZ / 1000;
   localparam int unsigned RST_LONG_TICKS = RST_LONG_MS * TB_HZ / 1000;
   localparam int unsigned WD_SLOW_TICKS = WD_SLOW_MS * TB_HZ / 1000;
   localparam int unsigned WD_FAST_TICKS = WD_FAST_MS * TB_HZ / 1000;
   localparam int unsigned EXT_WD_NORM_CLKS = 1024;
   localparam int unsigned EXT_WD_AFTER_CLKS = 4096;
   localparam int unsigned EXT_RST_SHORT_CLKS = 512;
   localparam int unsigned EXT_RST_LONG_CLKS = 2048;
   localparam int unsigned CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam int unsigned SYNC_STAGES = 3;
endpackage : srw_pkg

// >>> srw_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to mclk; the output changes only when
 * the second and third stages agree, so the first stage feeds nothing else.
 */
`timescale 1ns/1ps
module srw_sync
   import srw_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reset_value,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   logic [SYNC_STAGES-1:0] stage_q;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         stage_q <= {SYNC_STAGES{reset_value}};
      end
      else
      begin
         stage_q <= {stage_q[SYNC_STAGES-2:0], async_in};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sync_out <= reset_value;
      end
      else if (stage_q[1] == stage_q[2])
      begin
         sync_out <= stage_q[2];
      end
   end

endmodule : srw_sync

// >>> srw_top.sv
/*
 * Supervisor reset and watchdog: stretched reset from supply-low, watchdog
 * with longer post-reset timeout, latched fault output, memory chip-select
 * gating and power-fail warning. Analog comparators sit outside and arrive
 * as digital levels; pins from outside pass a three-stage synchroniser and agreement filter.
 */
// Contract
// - Reset low while supply low, then held a further 50 or 200 ms.
// - With watchdog enabled, reset when kick stays constant beyond the timeout.
// - Watchdog timeout gives a reset pulse of configured width, not a level.
// - Longer timeout after any reset until first kick transition after release.
// - Watchdog counter restarts whenever a reset ends.
// - A kick that never changes yields periodic reset pulses, about 1.6 s apart.
// - Floating kick input disables watchdog resets and fault indication.
// - Timeout drives fault output low until next kick transition.
// - Supply below threshold forces fault output high, overriding latched fault.
// - Fixed-timing variant uses 1.6 s timeout and 50 ms reset width; the long-reset strap still selects 200 ms here.
// - Floating source select uses internal oscillator; input picks 1.6 s or 100 ms.
// - Internal oscillator always uses 1.6 s timeout right after reset.
// - Internal oscillator with input low switches to 100 ms after first kick.
// - Chip select passes through unchanged while supply is valid and backup mode is off.
// - Chip select output forced high while supply is below threshold.
// - Chip select output forced high in backup mode.
// - Power-fail warning low while sense input is below reference.
// - Backup mode holds power-fail warning low, ignoring sense input.
// - Active-high reset output is always the inverse of active-low reset.
// - Supply-low flag output low while supply is low, no added delay.
// - Internal timebase runs at nominal 6.55 kHz; periods count its ticks unless the external timebase pin is selected.
`timescale 1ns/1ps
module srw_top
   import srw_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Analog front end conditions
   input wire logic supply_low,
   input wire logic backup_mode,
   input wire logic powerfail_sense_in,
   input wire logic kick_floating,
   input wire logic timebase_source_floating,
   // Timebase pins
   input wire logic timebase_source_select,
   input wire logic timebase_input,
   // Variant straps
   input wire logic strap_fixed_timing,
   input wire logic strap_long_reset,
   // Processor side
   input wire logic watchdog_kick_in,
   output logic reset_out_n,
   output logic reset_out,
   output logic watchdog_fault_out_n,
   output logic powerfail_warn_out_n,
   output logic supply_low_flag_n,
   output logic backup_active_flag,
   // Memory chip select
   input wire logic mem_cs_in_n,
   output logic mem_cs_out_n
);
   // HOLD covers power-up and supply-low reset; PULSE is a watchdog reset.
   typedef enum logic [2:0]
   {
      SRW_HOLD = 3'h1,
      SRW_PULSE = 3'h2,
      SRW_RUN = 3'h4
   } srw_state_t;

   srw_state_t state_q;
   logic kick_s, tbin_s, tbsel_s, pfs_s, cs_s;
   logic kick_prev_q;
   logic kick_edge;
   logic tbin_prev_q;
   logic ext_tick;
   logic [TB_DIV_W-1:0] div_q;
   logic int_tick;
   logic tick;
   logic use_internal;
   logic after_reset_q;
   logic [CNT_W-1:0] rst_cnt_q;
   logic [CNT_W-1:0] wd_cnt_q;
   logic [CNT_W-1:0] rst_len;
   logic [CNT_W-1:0] wd_len;
   logic wd_enabled;
   logic wd_expire;
   logic fault_q;

   // Pin inputs from outside the mclk domain.
   // Idle-high pins reset high, so no false select or warning follows reset.
   srw_sync u_sync_kick (.mclk(mclk), .rst_n(rst_n), .reset_value(1'b0),
      .async_in(watchdog_kick_in), .sync_out(kick_s));
   srw_sync u_sync_tbin (.mclk(mclk), .rst_n(rst_n), .reset_value(1'b0),
      .async_in(timebase_input), .sync_out(tbin_s));
   srw_sync u_sync_tbsel (.mclk(mclk), .rst_n(rst_n), .reset_value(1'b0),
      .async_in(timebase_source_select), .sync_out(tbsel_s));
   srw_sync u_sync_pfs (.mclk(mclk), .rst_n(rst_n), .reset_value(1'b1),
      .async_in(powerfail_sense_in), .sync_out(pfs_s));
   srw_sync u_sync_cs (.mclk(mclk), .rst_n(rst_n), .reset_value(1'b1),
      .async_in(mem_cs_in_n), .sync_out(cs_s));

   // Floating source select or a high level keeps the internal oscillator.
   assign use_internal = strap_fixed_timing | timebase_source_floating | tbsel_s;

   // Internal timebase divider, one-cycle tick enable.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         div_q <= '0;
      end
      else if (div_q == TB_DIV_W'(TB_DIV_CYCLES - 1))
      begin
         div_q <= '0;
      end
      else
      begin
         div_q <= div_q + 1'b1;
      end
   end
   assign int_tick = (div_q == TB_DIV_W'(TB_DIV_CYCLES - 1));

   // External clock on the timebase pin counts rising edges.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         tbin_prev_q <= 1'b0;
      end
      else
      begin
         tbin_prev_q <= tbin_s;
      end
   end
   assign ext_tick = tbin_s & ~tbin_prev_q;
   assign tick = use_internal ? int_tick : ext_tick;

   // Kick transitions are seen on mclk so none is missed between ticks.
   // A floating pin can show any level, so its edges are masked.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         kick_prev_q <= 1'b0;
      end
      else
      begin
         kick_prev_q <= kick_s;
      end
   end
   assign kick_edge = (kick_s != kick_prev_q) & ~kick_floating;

   assign wd_enabled = ~kick_floating;

   // Timing selection from straps and timebase pins.
   // After any reset the internal mode keeps the slow period whatever the pin shows.
   always_comb
   begin
      if (!use_internal)
      begin
         rst_len = strap_long_reset ? CNT_W'(EXT_RST_LONG_CLKS) : CNT_W'(EXT_RST_SHORT_CLKS);
         wd_len = after_reset_q ? CNT_W'(EXT_WD_AFTER_CLKS) : CNT_W'(EXT_WD_NORM_CLKS);
      end
      else
      begin
         rst_len = strap_long_reset ? CNT_W'(RST_LONG_TICKS) : CNT_W'(RST_SHORT_TICKS);
         if (after_reset_q || strap_fixed_timing || tbin_s)
         begin
            wd_len = CNT_W'(WD_SLOW_TICKS);
         end
         else
         begin
            wd_len = CNT_W'(WD_FAST_TICKS);
         end
      end
   end

   // Expiry falls on the last tick of the period; a kick in that same cycle wins.
   // The pulse width that follows obeys the long-reset strap in every variant.
   assign wd_expire = (state_q == SRW_RUN) & wd_enabled & tick & (wd_cnt_q >= wd_len - CNT_ONE)
      & ~kick_edge;

   // Reset sequencer.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_q <= SRW_HOLD;
      end
      else if (supply_low)
      begin
         state_q <= SRW_HOLD;
      end
      else
      begin
         unique case (state_q)
            SRW_HOLD, SRW_PULSE:
            begin
               if (tick && rst_cnt_q >= rst_len - CNT_ONE)
               begin
                  state_q <= SRW_RUN;
               end
            end
            SRW_RUN:
            begin
               if (wd_expire)
               begin
                  state_q <= SRW_PULSE;
               end
            end
         endcase
      end
   end

   // Reset width counter runs during hold and pulse, cleared while supply is low.
   // Greater-or-equal compares recover if a strap shortens the width mid-count.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || supply_low || state_q == SRW_RUN)
      begin
         rst_cnt_q <= CNT_ZERO;
      end
      else if (tick)
      begin
         rst_cnt_q <= rst_cnt_q + CNT_ONE;
      end
   end

   // Watchdog counter restarts at the end of every reset and on each kick.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || state_q != SRW_RUN || kick_edge || !wd_enabled)
      begin
         wd_cnt_q <= CNT_ZERO;
      end
      else if (wd_expire)
      begin
         wd_cnt_q <= CNT_ZERO;
      end
      else if (tick)
      begin
         wd_cnt_q <= wd_cnt_q + CNT_ONE;
      end
   end

   // Long timeout applies from any reset until the first kick after release.
   // Software often cannot kick at once after reset, hence the long period.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || state_q != SRW_RUN)
      begin
         after_reset_q <= 1'b1;
      end
      else if (kick_edge)
      begin
         after_reset_q <= 1'b0;
      end
   end

   // Fault latch; supply-low clearing wins over a simultaneous timeout.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || supply_low || !wd_enabled)
      begin
         fault_q <= 1'b0;
      end
      else if (wd_expire)
      begin
         fault_q <= 1'b1;
      end
      else if (kick_edge)
      begin
         fault_q <= 1'b0;
      end
   end

   // Registered outputs.
   // Pins come from flops so that no decode glitch reaches the processor.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         reset_out_n <= 1'b0;
         reset_out <= 1'b1;
         watchdog_fault_out_n <= 1'b1;
         powerfail_warn_out_n <= 1'b0;
         supply_low_flag_n <= 1'b0;
         backup_active_flag <= 1'b0;
         mem_cs_out_n <= 1'b1;
      end
      else
      begin
         reset_out_n <= ~supply_low & (state_q == SRW_RUN) & ~wd_expire;
         reset_out <= supply_low | (state_q != SRW_RUN) | wd_expire;
         watchdog_fault_out_n <= ~(fault_q | wd_expire) | supply_low;
         powerfail_warn_out_n <= ~backup_mode & pfs_s;
         supply_low_flag_n <= ~supply_low;
         backup_active_flag <= backup_mode;
         mem_cs_out_n <= cs_s | supply_low | backup_mode;
      end
   end
endmodule : srw_top

// >>> srw_properties.sv
/* Port assertions for srw_top: reset, fault, flags and chip-select gating.
   Assumes it is bound to srw_top and shares its clock and reset. */
`timescale 1ns/1ps
module srw_properties
   import srw_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Conditions
   input wire logic supply_low,
   input wire logic backup_mode,
   input wire logic kick_floating,
   // Outputs watched
   input wire logic reset_out_n,
   input wire logic reset_out,
   input wire logic watchdog_fault_out_n,
   input wire logic powerfail_warn_out_n,
   input wire logic supply_low_flag_n,
   input wire logic backup_active_flag,
   input wire logic mem_cs_out_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_reset_inverse: assert property (reset_out == !reset_out_n)
      else $error("reset outputs disagree");
   a_supply_reset: assert property (supply_low [*3] |-> !reset_out_n)
      else $error("reset high while supply low");
   a_supply_fault: assert property (supply_low [*3] |-> watchdog_fault_out_n)
      else $error("fault low while supply low");
   a_supply_flag: assert property (1'b1 |=> supply_low_flag_n == !$past(supply_low))
      else $error("supply flag wrong");
   a_backup_copy: assert property (1'b1 |=> backup_active_flag == $past(backup_mode))
      else $error("backup flag wrong");
   a_cs_forced: assert property ((supply_low || backup_mode) |=> mem_cs_out_n)
      else $error("chip select not forced high");
   a_pfo_backup: assert property (backup_mode |=> !powerfail_warn_out_n)
      else $error("warning high in backup");
   a_fault_reset: assert property ($fell(watchdog_fault_out_n) |-> !reset_out_n)
      else $error("fault without reset pulse");
   a_float_quiet: assert property (kick_floating [*3] |-> watchdog_fault_out_n)
      else $error("fault while watchdog off");
   c_fault: cover property ($fell(watchdog_fault_out_n));
   c_supply: cover property (supply_low ##1 !supply_low);
   c_backup: cover property (backup_mode ##1 !powerfail_warn_out_n);
endmodule : srw_properties
bind srw_top srw_properties u_props (.mclk, .rst_n, .supply_low, .backup_mode, .kick_floating,
   .reset_out_n, .reset_out, .watchdog_fault_out_n, .powerfail_warn_out_n, .supply_low_flag_n,
   .backup_active_flag, .mem_cs_out_n);

// >>> srw_cpu_model.sv
/* Processor and external oscillator model: six mclk per timebase tick.
   Assumes each toggle of kick_req asks for one kick of the watchdog pin. */
`timescale 1ns/1ps
module srw_cpu_model
   import srw_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Requests and status
   input wire logic kick_req,
   input wire logic kick_floating,
   input wire logic reset_out_n,
   // Pins
   output logic timebase_input,
   output logic watchdog_kick_in
);
   logic [2:0] div_q = 3'h0;
   logic seen_q = 1'b0;
   logic lvl_q = 1'b0;
   initial watchdog_kick_in = 1'b0;
   always @(posedge mclk)
   begin
      div_q <= (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
   end
   assign timebase_input = (div_q < 3'h3);
   // Software leaves the port alone while held in reset, so a request may be served late.
   always @(posedge mclk)
   begin
      if (kick_req != seen_q && reset_out_n)
      begin
         seen_q <= kick_req;
         lvl_q <= !lvl_q;
      end
   end
   // An undriven pin shows a level that flips every cycle, never a held value.
   always @(posedge mclk)
   begin
      watchdog_kick_in <= kick_floating ? !watchdog_kick_in : lvl_q;
   end
endmodule : srw_cpu_model

// >>> testbench.sv
/* Self-checking bench for srw_top on the external timebase.
   Assumes srw_cpu_model drives the kick and timebase pins. */
`timescale 1ns/1ps
module testbench;
   import srw_pkg::*;
   logic mclk, rst_n, supply_low, backup_mode, powerfail_sense_in, kick_floating, kick_req;
   logic mem_cs_in_n, timebase_input, watchdog_kick_in, reset_out_n, reset_out;
   logic watchdog_fault_out_n, powerfail_warn_out_n, supply_low_flag_n, backup_active_flag;
   logic mem_cs_out_n, strap_long_reset;
   int n_mismatch = 0;
   int check_count = 0;
   int t;
   srw_top DUT (.mclk, .rst_n, .supply_low, .backup_mode, .powerfail_sense_in,
      .kick_floating, .timebase_source_floating(1'b0), .timebase_source_select(1'b0),
      .timebase_input, .strap_fixed_timing(1'b0), .strap_long_reset,
      .watchdog_kick_in, .reset_out_n, .reset_out, .watchdog_fault_out_n,
      .powerfail_warn_out_n, .supply_low_flag_n, .backup_active_flag, .mem_cs_in_n,
      .mem_cs_out_n);
   srw_cpu_model u_cpu (.mclk, .kick_req, .kick_floating, .reset_out_n, .timebase_input,
      .watchdog_kick_in);
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = !mclk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Counts ticks while an output holds; the window absorbs the pin synchroniser lag.
   task automatic span(input string what, input bit on_fault, input int exp);
      t = 0;
      while ((on_fault ? watchdog_fault_out_n : !reset_out_n) === 1'b1 && t < 9000)
      begin
         @(posedge timebase_input);
         t++;
      end
      #1;
      check(what, 16'(t > exp - 4 && t < exp + 4), 16'h0001);
   endtask : span
   task automatic kick();
      @(posedge mclk);
      kick_req <= !kick_req;
      repeat (8) @(posedge mclk);
      #1;
   endtask : kick
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   initial
   begin
      #1600000;
      n_mismatch++;
      test_done();
   end
   initial
   begin
      {rst_n, supply_low, backup_mode, kick_floating, kick_req, strap_long_reset} = 6'h00;
      mem_cs_in_n = 1'b1;
      powerfail_sense_in = 1'b1;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      span("rst_width", 1'b0, EXT_RST_SHORT_CLKS);
      span("wd_after", 1'b1, EXT_WD_AFTER_CLKS);
      check("rst_out_n", reset_out_n, 1'b0);
      span("wd_pulse", 1'b0, EXT_RST_SHORT_CLKS);
      check("fault_held", watchdog_fault_out_n, 1'b0);
      kick();
      check("fault_clear", watchdog_fault_out_n, 1'b1);
      span("wd_norm", 1'b1, EXT_WD_NORM_CLKS);
      span("wd_pulse2", 1'b0, EXT_RST_SHORT_CLKS);
      $display("test watchdog done");
      @(posedge mclk);
      supply_low <= 1'b1;
      mem_cs_in_n <= 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      check("rst_low", {reset_out_n, reset_out}, 2'b01);
      check("fault_forced", watchdog_fault_out_n, 1'b1);
      check("flag_low", supply_low_flag_n, 1'b0);
      check("cs_forced", mem_cs_out_n, 1'b1);
      @(posedge mclk);
      supply_low <= 1'b0;
      @(posedge mclk);
      span("rst_supply", 1'b0, EXT_RST_SHORT_CLKS);
      check("cs_pass", {mem_cs_out_n, supply_low_flag_n}, 2'b01);
      @(posedge mclk);
      strap_long_reset <= 1'b1;
      supply_low <= 1'b1;
      repeat (4) @(posedge mclk);
      supply_low <= 1'b0;
      @(posedge mclk);
      span("rst_long", 1'b0, EXT_RST_LONG_CLKS);
      @(posedge mclk);
      strap_long_reset <= 1'b0;
      $display("test supply done");
      kick();
      @(posedge mclk);
      kick_floating <= 1'b1;
      repeat (1500) @(posedge timebase_input);
      #1;
      check("float_quiet", {reset_out_n, watchdog_fault_out_n}, 2'b11);
      $display("test floating done");
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         {backup_mode, mem_cs_in_n, powerfail_sense_in} <= 3'(i);
         repeat (8) @(posedge mclk);
         #1;
         check("cs_out", mem_cs_out_n, backup_mode | mem_cs_in_n);
         check("pfo", powerfail_warn_out_n, powerfail_sense_in & !backup_mode);
         check("batt", backup_active_flag, backup_mode);
      end
      $display("test gating done");
      test_done();
   end
endmodule : testbench
